// ===== rtl/guard_pkg.sv
package guard_pkg;

    localparam int GUARD_COUNT = 2;
    localparam int GATE_COUNT = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PROT_W = 8;
    localparam int IDX_W = 3;

    localparam logic [ADDR_W-1:0] OFS_PROTECT_CLEAR = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PROTECT_SET = 8'h04;

    // Bridge A: power, system control, clock, watchdog, real-time and external-interrupt units.
    localparam int POWER_MANAGER_BIT = 1;
    localparam int SYSTEM_CONTROL_BIT = 2;
    localparam int GENERIC_CLOCK_BIT = 3;
    localparam int WATCHDOG_BIT = 4;
    localparam int REAL_TIME_BIT = 5;
    localparam int EXT_INTERRUPT_UNIT_BIT = 6;
    // Bridge B: debug support, flash control, pin port and trace buffer.
    localparam int DEBUG_SUPPORT_BIT = 1;
    localparam int FLASH_CONTROLLER_BIT = 2;
    localparam int PIN_PORT_BIT = 3;
    localparam int TRACE_BUFFER_BIT = 6;

    localparam logic [PROT_W-1:0] MASK_BRIDGE_A = PROT_W'((1 << POWER_MANAGER_BIT)
        | (1 << SYSTEM_CONTROL_BIT) | (1 << GENERIC_CLOCK_BIT) | (1 << WATCHDOG_BIT)
        | (1 << REAL_TIME_BIT) | (1 << EXT_INTERRUPT_UNIT_BIT));
    localparam logic [PROT_W-1:0] MASK_BRIDGE_B = PROT_W'((1 << DEBUG_SUPPORT_BIT)
        | (1 << FLASH_CONTROLLER_BIT) | (1 << PIN_PORT_BIT) | (1 << TRACE_BUFFER_BIT));

    localparam logic [PROT_W-1:0] RESET_BRIDGE_A = 8'h00;
    localparam logic [PROT_W-1:0] RESET_BRIDGE_B = 8'h02;

    localparam logic [GUARD_COUNT-1:0][PROT_W-1:0] GUARD_MASKS = {MASK_BRIDGE_B, MASK_BRIDGE_A};
    localparam logic [GUARD_COUNT-1:0][PROT_W-1:0] GUARD_RESETS =
        {RESET_BRIDGE_B, RESET_BRIDGE_A};

    // Gate bits: 0 bridge A, 1 bridge B, 2 third bridge (stopped at reset).
    localparam logic [GATE_COUNT-1:0] GATE_RESET = 3'h3;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic slverr;
    } bus_rsp_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
        logic debug;
    } periph_wr_t;

endpackage

// ===== rtl/periph_guard.sv
// Functional notes
// - One guard per bridge, own peripherals only; the third bridge has no guard here.
// - Gated bus clocks; A, B on, third off.
// - Guard runs in sleep while clock source runs.
// - Debugger writes ignore every protect bit.
// - Writing zero to set or clear: no change.
// - Clear register one removes protection.
// - Reads return protect state, one is protected.
// - Reset: bridge B 0x02, bridge A zero.
// - Bridge A bit map, bits 0,7 unused.
// - Bridge B bit map, bits 0,4,5,7 unused.
// - Clear at 0x00, set at 0x04.
module periph_guard (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pwr_gate_wr,
    input wire logic [guard_pkg::GATE_COUNT-1:0] pwr_gate_val,
    input wire logic [guard_pkg::GUARD_COUNT-1:0] src_running,
    input guard_pkg::bus_req_t [guard_pkg::GUARD_COUNT-1:0] bus_req,
    output guard_pkg::bus_rsp_t [guard_pkg::GUARD_COUNT-1:0] bus_rsp,
    input guard_pkg::periph_wr_t [guard_pkg::GUARD_COUNT-1:0] wr_req,
    output logic [guard_pkg::GUARD_COUNT-1:0] wr_allow,
    output logic [guard_pkg::GUARD_COUNT-1:0] wr_denied_r,
    output logic [guard_pkg::GUARD_COUNT-1:0][guard_pkg::PROT_W-1:0] prot_state,
    output logic [guard_pkg::GATE_COUNT-1:0] gate_on_r
);
    import guard_pkg::*;

    logic [GUARD_COUNT-1:0] active;
    logic [GUARD_COUNT-1:0] blocked;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // The power manager owns the gates; this block only holds their state.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gate_on_r <= GATE_RESET;
        end else if (pwr_gate_wr) begin
            gate_on_r <= pwr_gate_val;
        end
    end

    // One flop vector for all guards keeps a single process driving it.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_denied_r <= '0;
        end else begin
            wr_denied_r <= blocked;
        end
    end

    a_gate_follow: assert property (pwr_gate_wr |=> gate_on_r == $past(pwr_gate_val))
        else $error("Gate state did not follow the power manager write.");

    a_gate_hold: assert property (!pwr_gate_wr |=> $stable(gate_on_r))
        else $error("Gate state changed without a power manager write.");

    genvar g;
    generate
        for (g = 0; g < GUARD_COUNT; g++) begin : guard
            // Sleep does not stop the guard; only a stopped clock or source does.
            assign active[g] = gate_on_r[g] && src_running[g];

            // Each guard sees only its own bridge's requests.
            periph_guard_regs #(
                .RESET_VAL(GUARD_RESETS[g]),
                .MASK(GUARD_MASKS[g])
            ) regs (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .clk_on(active[g]),
                .req(bus_req[g]),
                .rsp(bus_rsp[g]),
                .prot(prot_state[g])
            );

            assign blocked[g] = wr_req[g].valid && !wr_req[g].debug
                && prot_state[g][wr_req[g].idx];
            assign wr_allow[g] = wr_req[g].valid && !blocked[g];

            sequence seq_setup(logic [ADDR_W-1:0] ofs);
                active[g] && bus_req[g].sel && !bus_req[g].enable && bus_req[g].addr == ofs;
            endsequence

            sequence seq_write(logic [ADDR_W-1:0] ofs);
                active[g] && bus_req[g].sel && bus_req[g].enable && bus_req[g].write
                    && bus_req[g].addr == ofs;
            endsequence

            a_debug_bypass: assert property (
                wr_req[g].valid && wr_req[g].debug |-> wr_allow[g])
                else $error("Debugger write was blocked.");

            a_protected_block: assert property (
                wr_req[g].valid && !wr_req[g].debug && prot_state[g][wr_req[g].idx]
                |-> !wr_allow[g] ##1 wr_denied_r[g])
                else $error("Protected write was let through or not flagged.");

            a_open_write: assert property (
                wr_req[g].valid && !prot_state[g][wr_req[g].idx] |-> wr_allow[g])
                else $error("Write to an unprotected peripheral was blocked.");

            a_denied_quiet: assert property (
                !(wr_req[g].valid && !wr_req[g].debug && prot_state[g][wr_req[g].idx])
                |=> !wr_denied_r[g])
                else $error("Denied flag raised without a blocked write.");

            a_set_effect: assert property (
                seq_write(OFS_PROTECT_SET)
                |=> prot_state[g] == ($past(prot_state[g])
                    | ($past(bus_req[g].wdata[PROT_W-1:0]) & GUARD_MASKS[g])))
                else $error("Set write did not raise the selected bits.");

            a_clear_effect: assert property (
                seq_write(OFS_PROTECT_CLEAR)
                |=> prot_state[g] == ($past(prot_state[g])
                    & ~$past(bus_req[g].wdata[PROT_W-1:0])))
                else $error("Clear write did not drop the selected bits.");

            a_zero_noop: assert property (
                (seq_write(OFS_PROTECT_SET) or seq_write(OFS_PROTECT_CLEAR))
                    ##0 (bus_req[g].wdata[PROT_W-1:0] == 8'h00)
                |=> $stable(prot_state[g]))
                else $error("Writing zeros changed the protect state.");

            a_unmapped_err: assert property (
                bus_req[g].sel && bus_req[g].enable && bus_req[g].addr != OFS_PROTECT_CLEAR
                    && bus_req[g].addr != OFS_PROTECT_SET
                |-> bus_rsp[g].slverr ##1 $stable(prot_state[g]))
                else $error("Unmapped access was not refused or changed the state.");

            a_gated_hold: assert property (!active[g] |=> $stable(prot_state[g]))
                else $error("Protect state changed while the clock was stopped.");

            a_ready_gate: assert property (bus_rsp[g].ready == active[g])
                else $error("Ready does not follow the guard clock state.");

            a_gated_rdata: assert property (!active[g] |=> $stable(bus_rsp[g].rdata))
                else $error("Read data changed while the clock was stopped.");

            a_unused_zero: assert property (
                (prot_state[g] & ~GUARD_MASKS[g]) == 8'h00)
                else $error("An unused protect position became set.");

            a_read_back: assert property (
                (seq_setup(OFS_PROTECT_CLEAR) or seq_setup(OFS_PROTECT_SET))
                |=> bus_rsp[g].rdata == {24'h000000, $past(prot_state[g])})
                else $error("Read data does not show the protect state.");
        end
    endgenerate

    a_reset_value: assert property (
        $rose(rstn) |-> prot_state[0] == RESET_BRIDGE_A && prot_state[1] == RESET_BRIDGE_B)
        else $error("Protect state wrong at reset release.");

endmodule

// ===== rtl/periph_guard_regs.sv
module periph_guard_regs #(
    parameter logic [guard_pkg::PROT_W-1:0] RESET_VAL = 8'h00,
    parameter logic [guard_pkg::PROT_W-1:0] MASK = 8'h00
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_on,
    input guard_pkg::bus_req_t req,
    output guard_pkg::bus_rsp_t rsp,
    output logic [guard_pkg::PROT_W-1:0] prot
);
    import guard_pkg::*;

    logic [PROT_W-1:0] prot_r;
    logic [DATA_W-1:0] rdata_r;
    logic hit_clr;
    logic hit_set;
    logic wr_go;
    logic [PROT_W-1:0] wbits;

    assign hit_clr = (req.addr == OFS_PROTECT_CLEAR);
    assign hit_set = (req.addr == OFS_PROTECT_SET);
    assign wr_go = clk_on && req.sel && req.enable && req.write;
    // Unused positions can never be set, so they always read as zero.
    assign wbits = req.wdata[PROT_W-1:0] & MASK;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prot_r <= RESET_VAL;
        end else if (wr_go && hit_clr) begin
            prot_r <= prot_r & ~wbits;
        end else if (wr_go && hit_set) begin
            prot_r <= prot_r | wbits;
        end
    end

    // Read data is captured in the setup phase so it comes from a flop.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_on && req.sel && !req.enable) begin
            if (hit_clr || hit_set) begin
                rdata_r <= {{(DATA_W-PROT_W){1'b0}}, prot_r};
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    assign prot = prot_r;
    assign rsp.rdata = rdata_r;
    assign rsp.ready = clk_on;
    assign rsp.slverr = req.sel && req.enable && !(hit_clr || hit_set);

endmodule

// ===== tb/bus_bridge_model.sv
module bus_bridge_model
    import guard_pkg::*;
(
    input wire logic sys_clk,
    output bus_req_t [GUARD_COUNT-1:0] bus_req,
    input wire bus_rsp_t [GUARD_COUNT-1:0] bus_rsp
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        bus_req = '0;
    end

    // The request is launched at a falling edge and held until ready is sampled high.
    // A gated guard never answers, so the wait is bounded and the caller judges ok.
    task automatic xfer(input int g, input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
                        output logic err, output logic ok);
        int n;
        ok = 1'b0;
        err = 1'b0;
        rdata = '0;
        @(negedge sys_clk);
        bus_req[g] = '{sel: 1'b1, enable: 1'b0, write: wr, addr: addr, wdata: wdata};
        @(negedge sys_clk);
        bus_req[g].enable = 1'b1;
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge sys_clk);
            if (bus_rsp[g].ready === 1'b1) begin
                ok = 1'b1;
                rdata = bus_rsp[g].rdata;
                err = bus_rsp[g].slverr;
            end
        end
        @(negedge sys_clk);
        // A released bus drops sel and enable and drives the inverted write, address and data.
        bus_req[g] = '{sel: 1'b0, enable: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
    endtask
endmodule

// ===== tb/periph_guard_tb.sv
module periph_guard_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import guard_pkg::*;
    logic sys_clk, rstn, pwr_gate_wr, er, ok;
    logic [GATE_COUNT-1:0] pwr_gate_val, gate_on_r;
    logic [GUARD_COUNT-1:0] src_running, wr_allow, wr_denied_r;
    bus_req_t [GUARD_COUNT-1:0] bus_req;
    bus_rsp_t [GUARD_COUNT-1:0] bus_rsp;
    periph_wr_t [GUARD_COUNT-1:0] wr_req;
    logic [GUARD_COUNT-1:0][PROT_W-1:0] prot_state;
    logic [31:0] rd;
    int num_errors = 0;
    int checks_done = 0;

    periph_guard uut (.sys_clk(sys_clk), .rstn(rstn), .pwr_gate_wr(pwr_gate_wr),
        .pwr_gate_val(pwr_gate_val), .src_running(src_running), .bus_req(bus_req),
        .bus_rsp(bus_rsp), .wr_req(wr_req), .wr_allow(wr_allow), .wr_denied_r(wr_denied_r),
        .prot_state(prot_state), .gate_on_r(gate_on_r));
    bus_bridge_model bridge (.sys_clk(sys_clk), .bus_req(bus_req), .bus_rsp(bus_rsp));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic acc(input int g, input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic must_answer);
        bridge.xfer(g, w, a, d, rd, er, ok);
        if (must_answer && ok !== 1'b1) begin
            check(32'(ok), 32'h1);
            end_of_test();
        end
    endtask

    task automatic gate(input logic [2:0] v);
        @(negedge sys_clk);
        pwr_gate_wr = 1'b1;
        pwr_gate_val = v;
        @(negedge sys_clk);
        pwr_gate_wr = 1'b0;
    endtask

    task automatic t_reset();
        check(32'(gate_on_r), 32'h3);
        for (int g = 0; g < GUARD_COUNT; g++) begin
            acc(g, 1'b0, OFS_PROTECT_CLEAR, 32'h0, 1'b1);
            check(rd, 32'(GUARD_RESETS[g]));
            acc(g, 1'b0, OFS_PROTECT_SET, 32'h0, 1'b1);
            check(rd, 32'(GUARD_RESETS[g]));
        end
        $display("test reset done");
    endtask

    task automatic t_set_clear();
        logic [7:0] e;
        e = MASK_BRIDGE_A & ~(8'h01 << WATCHDOG_BIT);
        acc(0, 1'b1, OFS_PROTECT_SET, 32'hffff_ffff, 1'b1);
        check(32'(prot_state[0]), 32'(MASK_BRIDGE_A));
        check(32'(er), 32'h0);
        check(32'(prot_state[1]), 32'(RESET_BRIDGE_B));
        acc(0, 1'b1, OFS_PROTECT_CLEAR, 32'(8'h01 << WATCHDOG_BIT), 1'b1);
        check(32'(prot_state[0]), 32'(e));
        acc(0, 1'b1, OFS_PROTECT_SET, 32'h0, 1'b1);
        acc(0, 1'b1, OFS_PROTECT_CLEAR, 32'h0, 1'b1);
        acc(0, 1'b0, OFS_PROTECT_CLEAR, 32'h0, 1'b1);
        check(rd, 32'(e));
        acc(1, 1'b1, OFS_PROTECT_SET, 32'hffff_ffff, 1'b1);
        check(32'(prot_state[1]), 32'(MASK_BRIDGE_B));
        $display("test set clear done");
    endtask

    // Every bit position, plain and debugger, on both bridges.
    // Bridge A has all but the watchdog bit set, bridge B all of its bits.
    task automatic t_filter();
        logic [7:0] pv;
        logic p;
        for (int g = 0; g < GUARD_COUNT; g++) begin
            pv = (g == 0) ? (MASK_BRIDGE_A & ~(8'h01 << WATCHDOG_BIT)) : MASK_BRIDGE_B;
            for (int i = 0; i < 16; i++) begin
                p = pv[i % 8];
                @(negedge sys_clk);
                wr_req[g] = '{valid: 1'b1, idx: 3'(i % 8), debug: 1'(i / 8)};
                @(posedge sys_clk);
                check(32'(wr_allow[g]), 32'((i / 8 == 1) || !p));
                @(negedge sys_clk);
                check(32'(wr_denied_r[g]), 32'((i / 8 == 0) && p));
                wr_req[g].valid = 1'b0;
            end
        end
        $display("test filter done");
    endtask

    task automatic t_unmapped();
        acc(0, 1'b1, 8'h08, 32'hffff_ffff, 1'b1);
        check(32'(er), 32'h1);
        check(32'(prot_state[0]), 32'(MASK_BRIDGE_A & ~(8'h01 << WATCHDOG_BIT)));
        acc(0, 1'b0, 8'h08, 32'h0, 1'b1);
        check(rd, 32'h0);
        $display("test unmapped done");
    endtask

    task automatic t_gate();
        gate(3'h5);
        check(32'(gate_on_r), 32'h5);
        acc(1, 1'b1, OFS_PROTECT_CLEAR, 32'hff, 1'b0);
        check(32'(ok), 32'h0);
        check(32'(prot_state[1]), 32'(MASK_BRIDGE_B));
        src_running = 2'h2;
        acc(0, 1'b0, OFS_PROTECT_SET, 32'h0, 1'b0);
        check(32'(ok), 32'h0);
        src_running = 2'h3;
        gate(3'h3);
        acc(1, 1'b1, OFS_PROTECT_CLEAR, 32'hff, 1'b1);
        check(32'(prot_state[1]), 32'h0);
        $display("test gate done");
    endtask

    // A reset in mid-run must bring back the gate and protect states.
    task automatic t_mid_reset();
        gate(3'h1);
        @(negedge sys_clk);
        rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        check(32'(gate_on_r), 32'(GATE_RESET));
        check(32'(prot_state[0]), 32'(RESET_BRIDGE_A));
        check(32'(prot_state[1]), 32'(RESET_BRIDGE_B));
        acc(1, 1'b0, OFS_PROTECT_SET, 32'h0, 1'b1);
        check(rd, 32'(RESET_BRIDGE_B));
        $display("test mid reset done");
    endtask

    initial begin
        pwr_gate_wr = 1'b0;
        pwr_gate_val = 3'h3;
        src_running = 2'h3;
        wr_req = '0;
        rstn = 1'b0;
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        t_reset();
        t_set_clear();
        t_filter();
        t_unmapped();
        t_gate();
        t_mid_reset();
        end_of_test();
    end
endmodule
